// ### rtl/scdvc_pkg.sv
// shared constants, register map and helper functions of the synthesizer divider and calibration control
package scdvc_pkg;

  localparam int NUM_CHANNELS = 14;
  localparam int ADDR_W       = 12;
  localparam int DATA_W       = 8;

  // register offsets
  localparam logic [11:0] ADDR_XFER        = 12'h00F;
  localparam logic [11:0] ADDR_FB_CFG_A    = 12'h201;
  localparam logic [11:0] ADDR_VCO_CAL     = 12'h203;
  localparam logic [11:0] ADDR_FB_CFG_B    = 12'h204;
  localparam logic [11:0] ADDR_LOOP_FILTER = 12'h205;
  localparam logic [11:0] ADDR_FB_CFG_C    = 12'h207;
  localparam logic [11:0] ADDR_FB_CFG_D    = 12'h208;
  localparam logic [11:0] ADDR_SYNC        = 12'h32A;
  localparam logic [11:0] ADDR_CAL_STATUS  = 12'h509;
  // per-channel blocks, channel index added to the base
  localparam logic [11:0] ADDR_CH_DIV      = 12'h300;
  localparam logic [11:0] ADDR_CH_CTRL     = 12'h310;
  localparam logic [11:0] ADDR_CH_COARSE   = 12'h320;
  localparam logic [11:0] ADDR_CH_FINE     = 12'h330;

  // field positions
  localparam int BIT_XFER      = 0;
  localparam int BIT_CAL_START = 0;
  localparam int BIT_SYNC      = 0;
  localparam int BIT_ST_BUSY   = 0;
  localparam int BIT_ST_MISM   = 1;
  localparam int BIT_ST_FIRST  = 2;
  localparam int BIT_DOUBLER   = 5;
  localparam int BIT_IGN_SYNC  = 2;

  // reset values
  localparam logic [7:0] RST_FB_N    = 8'h0A;  // synth feedback divider 10
  localparam logic [7:0] RST_CAL_BA  = 8'h87;  // main count 7, swallow count 2 -> 30
  localparam logic [7:0] RST_REF     = 8'h01;  // ref divider 1, doubler off
  localparam logic [7:0] RST_M1      = 8'h03;  // vco output divider 3
  localparam logic [7:0] RST_ZERO    = 8'h00;
  localparam logic [7:0] RST_CH_CTRL = 8'h01;  // divider path from synthesizer

  // divider limits
  localparam logic [4:0] REF_DIV_MIN = 5'h01;
  localparam logic [2:0] M1_MIN      = 3'h3;
  localparam logic [2:0] M1_MAX      = 3'h5;
  localparam logic [2:0] CAL_PRESCALE = 3'h4;

  // channel sources
  typedef enum logic [1:0] {
    SRC_FIRST_LOOP = 2'h0,
    SRC_SYNTH_DIV  = 2'h1,
    SRC_SYSREF     = 2'h2,
    SRC_SYSREF_RT  = 2'h3
  } scdvc_src_t;

  // timing: calibration lasts this many phase-detector periods, one clock each here
  localparam int CAL_PFD_PERIODS   = 400000;
  localparam int AUTO_SYNC_CYCLES  = 4;

  // calibration divider total: prescaler times main count plus swallow count
  function automatic logic [7:0] calTotal(input logic [7:0] cfg);
    calTotal = 8'(CAL_PRESCALE * cfg[5:0]) + {6'h00, cfg[7:6]};
  endfunction : calTotal

  // a channel's divider is in its path for these sources
  function automatic logic usesDivider(input logic [1:0] src);
    usesDivider = (src == SRC_SYNTH_DIV) || (src == SRC_SYSREF_RT);
  endfunction : usesDivider

endpackage : scdvc_pkg

// ### rtl/scdvc_cal_engine.sv
// vco calibration sequencer: busy window of fixed length after a start pulse
`timescale 1ns/1ps
`default_nettype none
module scdvc_cal_engine
  import scdvc_pkg::*;
#(
  parameter int CAL_CYCLES = CAL_PFD_PERIODS
) (
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic startPulse,
  output logic      calBusy,
  output logic      calDonePulse
);

  localparam int CNT_W = $clog2(CAL_CYCLES + 1);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(CAL_CYCLES - 1);

  initial begin
    if (CAL_CYCLES < 1) $error("CAL_CYCLES must be at least 1");
  end

  logic [CNT_W-1:0] count_r;
  logic             busy_r;
  logic             done_r;

  // a start while busy is ignored so a run always completes its full length
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      busy_r  <= 1'b0;
      count_r <= '0;
      done_r  <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (!busy_r && startPulse) begin
        busy_r  <= 1'b1;
        count_r <= '0;
      end else if (busy_r) begin
        if (count_r == LAST) begin
          busy_r <= 1'b0;  // [R08]
          done_r <= 1'b1;
        end else begin
          count_r <= count_r + 1'b1;  // [R15]
        end
      end
    end
  end

  assign calBusy      = busy_r;
  assign calDonePulse = done_r;

endmodule : scdvc_cal_engine
`default_nettype wire

// ### rtl/scdvc_chan_div.sv
// one output channel: source select, 8-bit divider with duty correction, sync hold
`timescale 1ns/1ps
`default_nettype none
module scdvc_chan_div
  import scdvc_pkg::*;
#(
  parameter int DIV_W = 8
) (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic [DIV_W-1:0] ratioField,
  input  wire logic [5:0]       coarseDelay,
  input  wire logic [1:0]       srcSel,
  input  wire logic             hold,
  input  wire logic             firstLoopIn,
  input  wire logic             sysrefIn,
  output logic                  chanOut
);

  initial begin
    if (DIV_W < 5 || DIV_W > 8) $error("DIV_W must be 5..8");
  end

  logic [DIV_W:0] ratio;
  logic [DIV_W:0] cnt_r;
  logic [DIV_W:0] cntNxt;
  logic           q_r;
  logic           qNeg_r;
  logic           tog_r;
  logic           togNeg_r;
  logic           qPrev_r;
  logic           sysRt_r;
  logic           divOut;

  assign ratio  = {1'b0, ratioField} + 1'b1;  // field value plus one, 1 through 256 [R20]
  assign cntNxt = (cnt_r >= ratio - 1'b1) ? '0 : cnt_r + 1'b1;

  // counter restarts at the coarse offset while held; sync takes effect when hold drops [R19] [R18]
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= '0;
      q_r   <= 1'b0;
    end else if (hold) begin
      cnt_r <= {{(DIV_W-5){1'b0}}, coarseDelay} - 1'b1;
      q_r   <= 1'b0;
    end else begin
      cnt_r <= cntNxt;
      q_r   <= cntNxt < ((ratio + 1'b1) >> 1);
    end
  end

  // half-cycle trim for odd ratios and toggle pair for divide by one [R21]
  always_ff @(negedge clock or negedge resetn) begin
    if (!resetn) begin
      qNeg_r   <= 1'b0;
      togNeg_r <= 1'b0;
    end else begin
      qNeg_r   <= q_r;
      togNeg_r <= tog_r;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) tog_r <= 1'b0;
    else if (!hold) tog_r <= ~tog_r;
  end

  // divide by one is the clock itself, rebuilt from two flops so no gate sits on the clock net
  always_comb begin
    if (ratio == 1) divOut = tog_r ^ togNeg_r;
    else if (ratio[0]) divOut = q_r & qNeg_r;
    else divOut = q_r;
  end

  // sysref resampled on the divider rising edge
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      qPrev_r <= 1'b0;
      sysRt_r <= 1'b0;
    end else begin
      qPrev_r <= q_r;
      if (hold) sysRt_r <= 1'b0;
      else if (q_r && !qPrev_r) sysRt_r <= sysrefIn;
    end
  end

  // source mux; bypass sources pass straight through and ignore sync [R16]
  always_comb begin
    case (srcSel)
      SRC_FIRST_LOOP: chanOut = firstLoopIn;
      SRC_SYNTH_DIV:  chanOut = hold ? 1'b0 : divOut;
      SRC_SYSREF:     chanOut = sysrefIn;
      SRC_SYSREF_RT:  chanOut = hold ? 1'b0 : sysRt_r;
      default:        chanOut = 1'b0;
    endcase
  end

endmodule : scdvc_chan_div
`default_nettype wire

// ### rtl/scdvc_top.sv
// synthesizer divider settings, vco calibration control and output channel distribution
// How it works
// R01: reference divider takes 1 to 31; zero setting acts as one, up to 275 MHz input.
// R02: normal feedback is 8-bit feedback divider times vco output divider.
// R03: calibration divider feeds back only while calibrating, then normal path returns.
// R04: calibration divide is four times main count plus swallow; minimum sixteen.
// R05: vco output divider takes 3, 4 or 5 and feeds distribution.
// R06: host programs calibration total equal to feedback times output divider.
// R07: calibration starts on calibrate bit rising; bit never self-clears.
// R08: status bit reads one during calibration and clears itself after.
// R09: host may stage calibrate bit before the transfer strobe applies settings.
// R10: each finished calibration triggers an automatic output channel sync.
// R11: after reset synthesizer channels stay held until first calibration finishes.
// R12: host ensures valid oscillator clock and correct configuration before calibrating.
// R13: host recalibrates whenever vco frequency changes; calibration allowed anytime.
// R14: with doubler on, total must exceed sixteen, else host works around.
// R15: calibration lasts 400,000 phase detector periods; host timeout covers it.
// R16: fourteen channels, each with source select, 8-bit divider, delays, driver.
// R17: fine delay setting reaches every channel regardless of source.
// R18: coarse delay acts only where the channel divider is in the path.
// R19: sync resets divider-path channels; bypass channels are not synchronised.
// R20: channel divider ratio is field plus one, 1 through 256.
// R21: channel divider output is nominally 50% duty, odd ratios included.
// R22: host issues a sync after changing any channel divide value.
// R23: optional doubler multiplies the loop reference by two when enabled.
// R24: sync is set then cleared; channels restart on the clear.
// R25: calibrate bit is registered and only its rising edge starts calibration.
`timescale 1ns/1ps
`default_nettype none
module scdvc_top
  import scdvc_pkg::*;
#(
  parameter int CAL_CYCLES = CAL_PFD_PERIODS,
  parameter int NUM_CH     = NUM_CHANNELS
) (
  input  wire logic                clock,
  input  wire logic                resetn,
  input  wire logic [ADDR_W-1:0]   regAddr,
  input  wire logic [DATA_W-1:0]   regWrData,
  input  wire logic                regWrEn,
  input  wire logic                regRdEn,
  output logic      [DATA_W-1:0]   regRdData,
  input  wire logic                firstLoopIn,
  input  wire logic                sysrefIn,
  output logic      [NUM_CH-1:0]   channelOut,
  output logic      [NUM_CH*5-1:0] fineDelayCfg,
  output logic      [4:0]          refDivide,
  output logic                     refDoublerEn,
  output logic      [10:0]         feedbackDivide,
  output logic                     calPathSelect,
  output logic      [7:0]          loopFilterCfg,
  output logic                     calBusy
);

  initial begin
    if (NUM_CH < 1 || NUM_CH > 16) $error("NUM_CH must be 1..16");
  end

  // staged copies written by the host, active copies applied by the transfer strobe
  logic [7:0] fbNStage_r, calBAStage_r, refStage_r, m1Stage_r, lfStage_r, calCtlStage_r, syncStage_r;
  logic [7:0] fbN_r, calBA_r, ref_r, m1_r, lf_r, calCtl_r, sync_r;
  logic [7:0] chDivStage_r [NUM_CH];
  logic [7:0] chCtlStage_r [NUM_CH];
  logic [7:0] chCrsStage_r [NUM_CH];
  logic [7:0] chFinStage_r [NUM_CH];
  logic [7:0] chDiv_r      [NUM_CH];
  logic [7:0] chCtl_r      [NUM_CH];
  logic [7:0] chCrs_r      [NUM_CH];
  logic [7:0] chFin_r      [NUM_CH];

  logic       wrXfer;
  logic       calPrev_r;
  logic       calStart;
  logic       calDone;
  logic       firstCalDone_r;
  logic [2:0] autoSyncCnt_r;
  logic       autoSyncActive;
  logic [2:0] m1Eff;
  logic [4:0] refEff;
  logic [7:0] calTot;
  logic [10:0] normTot;
  logic       calMismatch;
  logic [NUM_CH-1:0] chHold;

  localparam logic [2:0] AUTO_SYNC_LAST = 3'(AUTO_SYNC_CYCLES - 1);

  assign wrXfer = regWrEn && (regAddr == ADDR_XFER) && regWrData[BIT_XFER];

  // host writes land in the staged copies only
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      fbNStage_r    <= RST_FB_N;
      calBAStage_r  <= RST_CAL_BA;
      refStage_r    <= RST_REF;
      m1Stage_r     <= RST_M1;
      lfStage_r     <= RST_ZERO;
      calCtlStage_r <= RST_ZERO;
      syncStage_r   <= RST_ZERO;
      for (int i = 0; i < NUM_CH; i++) begin
        chDivStage_r[i] <= RST_ZERO;
        chCtlStage_r[i] <= RST_CH_CTRL;
        chCrsStage_r[i] <= RST_ZERO;
        chFinStage_r[i] <= RST_ZERO;
      end
    end else if (regWrEn) begin
      case (regAddr)
        ADDR_FB_CFG_A:    fbNStage_r    <= regWrData;
        ADDR_FB_CFG_B:    calBAStage_r  <= regWrData;
        ADDR_FB_CFG_C:    refStage_r    <= regWrData;
        ADDR_FB_CFG_D:    m1Stage_r     <= regWrData;
        ADDR_LOOP_FILTER: lfStage_r     <= regWrData;
        ADDR_VCO_CAL:     calCtlStage_r <= regWrData;  // [R09]
        ADDR_SYNC:        syncStage_r   <= regWrData;
        default: begin
          for (int i = 0; i < NUM_CH; i++) begin
            if (regAddr == ADDR_CH_DIV + 12'(i))    chDivStage_r[i] <= regWrData;
            if (regAddr == ADDR_CH_CTRL + 12'(i))   chCtlStage_r[i] <= regWrData;
            if (regAddr == ADDR_CH_COARSE + 12'(i)) chCrsStage_r[i] <= regWrData;
            if (regAddr == ADDR_CH_FINE + 12'(i))   chFinStage_r[i] <= regWrData;
          end
        end
      endcase
    end
  end

  // the transfer strobe copies every staged setting into the active set at once
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      fbN_r    <= RST_FB_N;
      calBA_r  <= RST_CAL_BA;
      ref_r    <= RST_REF;
      m1_r     <= RST_M1;
      lf_r     <= RST_ZERO;
      calCtl_r <= RST_ZERO;
      sync_r   <= RST_ZERO;
      for (int i = 0; i < NUM_CH; i++) begin
        chDiv_r[i] <= RST_ZERO;
        chCtl_r[i] <= RST_CH_CTRL;
        chCrs_r[i] <= RST_ZERO;
        chFin_r[i] <= RST_ZERO;
      end
    end else if (wrXfer) begin
      fbN_r    <= fbNStage_r;
      calBA_r  <= calBAStage_r;
      ref_r    <= refStage_r;
      m1_r     <= m1Stage_r;
      lf_r     <= lfStage_r;
      calCtl_r <= calCtlStage_r;  // calibrate bit stays as written [R07]
      sync_r   <= syncStage_r;
      for (int i = 0; i < NUM_CH; i++) begin
        chDiv_r[i] <= chDivStage_r[i];
        chCtl_r[i] <= chCtlStage_r[i];
        chCrs_r[i] <= chCrsStage_r[i];
        chFin_r[i] <= chFinStage_r[i];
      end
    end
  end

  // calibrate bit registered so a bit left high never restarts calibration
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) calPrev_r <= 1'b0;
    else calPrev_r <= calCtl_r[BIT_CAL_START];  // [R25]
  end

  assign calStart = calCtl_r[BIT_CAL_START] && !calPrev_r;  // [R07] [R25]

  scdvc_cal_engine #(
    .CAL_CYCLES (CAL_CYCLES)
  ) u_cal (
    .clock        (clock),
    .resetn       (resetn),
    .startPulse   (calStart),
    .calBusy      (calBusy),
    .calDonePulse (calDone)
  );

  // first-calibration flag releases the power-up hold on synthesizer channels
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) firstCalDone_r <= 1'b0;
    else if (calDone) firstCalDone_r <= 1'b1;  // [R11]
  end

  // automatic sync after every calibration: a short hold, released like a cleared sync bit
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) autoSyncCnt_r <= '0;
    else if (calDone) autoSyncCnt_r <= AUTO_SYNC_LAST + 3'h1;  // [R10]
    else if (autoSyncCnt_r != '0) autoSyncCnt_r <= autoSyncCnt_r - 3'h1;
  end

  assign autoSyncActive = (autoSyncCnt_r != '0);

  // divider values, clamped to the supported ranges
  assign refEff = (ref_r[4:0] < REF_DIV_MIN) ? REF_DIV_MIN : ref_r[4:0];  // [R01]
  always_comb begin
    if (m1_r[2:0] < M1_MIN) m1Eff = M1_MIN;  // [R05]
    else if (m1_r[2:0] > M1_MAX) m1Eff = M1_MAX;
    else m1Eff = m1_r[2:0];
  end

  assign calTot  = calTotal(calBA_r);  // [R04]
  assign normTot = 11'(fbN_r * m1Eff);  // [R02]
  assign calMismatch = ({3'h0, calTot} != normTot);  // visible check on the host's setup

  // feedback path switches to the calibration divider only while calibrating
  assign calPathSelect  = calBusy;  // [R03]
  assign feedbackDivide = calBusy ? {3'h0, calTot} : normTot;  // [R03] [R02]
  assign refDivide      = refEff;
  assign refDoublerEn   = ref_r[BIT_DOUBLER];  // [R23]
  assign loopFilterCfg  = lf_r;

  // per-channel hold: sync bit level holds dividers, release on its clear restarts them
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      chHold[i] = usesDivider(chCtl_r[i][1:0]) &&
                  ((!chCtl_r[i][BIT_IGN_SYNC] && (sync_r[BIT_SYNC] || autoSyncActive)) ||  // [R19] [R24]
                   (chCtl_r[i][1:0] == SRC_SYNTH_DIV && !firstCalDone_r));  // [R11]
    end
  end

  // channel instances; fine delay passes out for every source
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : gCh
      scdvc_chan_div #(
        .DIV_W (8)
      ) u_ch (
        .clock       (clock),
        .resetn      (resetn),
        .ratioField  (chDiv_r[g]),
        .coarseDelay (chCrs_r[g][5:0]),
        .srcSel      (chCtl_r[g][1:0]),
        .hold        (chHold[g]),
        .firstLoopIn (firstLoopIn),
        .sysrefIn    (sysrefIn),
        .chanOut     (channelOut[g])
      );  // [R16] [R20] [R21] [R18]
      assign fineDelayCfg[g*5 +: 5] = chFin_r[g][4:0];  // [R17]
    end
  endgenerate

  // register read: staged values read back, status from live state, unmapped reads zero
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      regRdData <= RST_ZERO;
    end else if (regRdEn) begin
      case (regAddr)
        ADDR_XFER:        regRdData <= RST_ZERO;
        ADDR_FB_CFG_A:    regRdData <= fbNStage_r;
        ADDR_FB_CFG_B:    regRdData <= calBAStage_r;
        ADDR_FB_CFG_C:    regRdData <= refStage_r;
        ADDR_FB_CFG_D:    regRdData <= m1Stage_r;
        ADDR_LOOP_FILTER: regRdData <= lfStage_r;
        ADDR_VCO_CAL:     regRdData <= calCtlStage_r;
        ADDR_SYNC:        regRdData <= syncStage_r;
        ADDR_CAL_STATUS: begin
          regRdData <= RST_ZERO;
          regRdData[BIT_ST_BUSY]  <= calBusy;  // [R08]
          regRdData[BIT_ST_MISM]  <= calMismatch;
          regRdData[BIT_ST_FIRST] <= firstCalDone_r;
        end
        default: begin
          regRdData <= RST_ZERO;
          for (int i = 0; i < NUM_CH; i++) begin
            if (regAddr == ADDR_CH_DIV + 12'(i))    regRdData <= chDivStage_r[i];
            if (regAddr == ADDR_CH_CTRL + 12'(i))   regRdData <= chCtlStage_r[i];
            if (regAddr == ADDR_CH_COARSE + 12'(i)) regRdData <= chCrsStage_r[i];
            if (regAddr == ADDR_CH_FINE + 12'(i))   regRdData <= chFinStage_r[i];
          end
        end
      endcase
    end
  end

endmodule : scdvc_top
`default_nettype wire

// ### dv/scdvc_top_properties.sv
// concurrent checks on the ports of the divider and calibration control top
`timescale 1ns/1ps
`default_nettype none
module scdvc_top_properties
  import scdvc_pkg::*;
#(
  parameter int CAL_CYCLES = CAL_PFD_PERIODS,
  parameter int NUM_CH     = NUM_CHANNELS
) (
  input wire logic              clock,
  input wire logic              resetn,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic              regWrEn,
  input wire logic              regRdEn,
  input wire logic [DATA_W-1:0] regRdData,
  input wire logic [NUM_CH-1:0] channelOut,
  input wire logic [4:0]        refDivide,
  input wire logic [10:0]       feedbackDivide,
  input wire logic              calPathSelect,
  input wire logic              calBusy
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  logic [31:0] busyCnt_r;
  logic [3:0]  xferAge_r;
  logic        firstDone_r;

  // busy length; restarts whenever calibration is idle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) busyCnt_r <= 32'h0;
    else if (calBusy) busyCnt_r <= busyCnt_r + 32'h1;
    else busyCnt_r <= 32'h0;
  end
  // cycles since the last applying transfer, saturating so it never wraps
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) xferAge_r <= 4'hF;
    else if (regWrEn && regAddr == ADDR_XFER && regWrData[BIT_XFER]) xferAge_r <= 4'h0;
    else if (xferAge_r != 4'hF) xferAge_r <= xferAge_r + 4'h1;
  end
  // first calibration seen finished since reset
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) firstDone_r <= 1'b0;
    else if (busyCnt_r != 32'h0 && !calBusy) firstDone_r <= 1'b1;
  end

  property p_path; calPathSelect == calBusy; endproperty
  a_path: assert property (p_path) else $error("cal path select differs from busy");
  property p_busy_len; $fell(calBusy) |-> busyCnt_r == CAL_CYCLES; endproperty
  a_busy_len: assert property (p_busy_len) else $error("calibration length wrong");
  property p_busy_min; $rose(calBusy) |-> calBusy [*8]; endproperty
  a_busy_min: assert property (p_busy_min) else $error("calibration ended too soon");
  property p_cal_start; $rose(calBusy) |-> xferAge_r <= 4'h4; endproperty
  a_cal_start: assert property (p_cal_start) else $error("calibration without transfer");
  property p_status;
    regRdEn && regAddr == ADDR_CAL_STATUS |=> regRdData[BIT_ST_BUSY] == $past(calBusy);
  endproperty
  a_status: assert property (p_status) else $error("status busy bit wrong");
  property p_rd_hold; !$past(regRdEn) |-> $stable(regRdData); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
  property p_ref; refDivide != 5'h00; endproperty
  a_ref: assert property (p_ref) else $error("reference divide zero");
  property p_cal_fb; calBusy |-> feedbackDivide >= 11'h010 && feedbackDivide <= 11'h0FF; endproperty
  a_cal_fb: assert property (p_cal_fb) else $error("cal divide out of range");
  property p_hold; !firstDone_r |-> channelOut[NUM_CH-1] == 1'b0; endproperty
  a_hold: assert property (p_hold) else $error("channel ran before first cal");
endmodule : scdvc_top_properties
bind scdvc_top scdvc_top_properties #(.CAL_CYCLES(CAL_CYCLES), .NUM_CH(NUM_CH)) u_props (
  .clock(clock), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
  .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .channelOut(channelOut),
  .refDivide(refDivide), .feedbackDivide(feedbackDivide), .calPathSelect(calPathSelect),
  .calBusy(calBusy));
`default_nettype wire

// ### dv/scdvc_host_model.sv
// host model: stages register writes and applies them with the transfer strobe
`timescale 1ns/1ps
`default_nettype none
module scdvc_host_model
  import scdvc_pkg::*;
(
  input  wire logic              clock,
  output logic      [ADDR_W-1:0] regAddr,
  output logic      [DATA_W-1:0] regWrData,
  output logic                   regWrEn,
  output logic                   regRdEn
);
  initial begin
    regAddr   = 12'h000;
    regWrData = 8'h00;
    regWrEn   = 1'b0;
    regRdEn   = 1'b0;
  end
  // strobe held over one rising edge; bus inverted once released
  task automatic access(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(negedge clock);
    regAddr   = a;
    regWrData = d;
    regWrEn   = w;
    regRdEn   = !w;
    @(negedge clock);
    regWrEn   = 1'b0;
    regRdEn   = 1'b0;
    regAddr   = ~a;
    regWrData = ~d;
  endtask : access
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    access(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    access(1'b0, a, 8'h00);
  endtask : rd
  task automatic xfer();
    wr(ADDR_XFER, 8'h01);
  endtask : xfer
  // feedback dividers and a matching calibration total; totals stay at or above 16
  task automatic setLoop(input logic [7:0] n, input logic [2:0] m);
    logic [7:0] tot;
    tot = 8'(n * m);
    wr(ADDR_FB_CFG_A, n);
    wr(ADDR_FB_CFG_D, {5'h00, m});
    wr(ADDR_FB_CFG_B, {tot[1:0], tot[7:2]});
  endtask : setLoop
  // calibrate bit cleared first, since the device never clears it
  task automatic calStart();
    wr(ADDR_VCO_CAL, 8'h00);
    xfer();
    wr(ADDR_VCO_CAL, 8'h01);
    xfer();
  endtask : calStart
endmodule : scdvc_host_model
`default_nettype wire

// ### dv/tb_top.sv
// self-checking bench for the divider and calibration control top
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; $display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_top
  import scdvc_pkg::*;
;
  localparam int CAL = 20;
  logic clock = 1'b0;
  logic resetn, firstLoopIn, sysrefIn, rdPend;
  logic [11:0] regAddr;
  logic [7:0] regWrData, regRdData, n, lf, rdExp;
  logic regWrEn, regRdEn, refDoublerEn, calPathSelect, calBusy;
  logic [13:0] channelOut;
  logic [69:0] fineDelayCfg;
  logic [4:0] refDivide, r;
  logic [10:0] feedbackDivide, fbExp;
  logic [7:0] loopFilterCfg;
  logic [2:0] m;
  logic [7:0] expQ[$];
  logic [7:0] divs[4] = '{8'h01, 8'h02, 8'h04, 8'hFF};
  int err_count = 0, checks = 0, cyc = 0, seed = 32'hc7e0;

  scdvc_host_model host (.clock(clock), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn));
  scdvc_top #(.CAL_CYCLES(CAL), .NUM_CH(14)) dut (.clock(clock), .resetn(resetn), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .firstLoopIn(firstLoopIn), .sysrefIn(sysrefIn), .channelOut(channelOut),
    .fineDelayCfg(fineDelayCfg), .refDivide(refDivide), .refDoublerEn(refDoublerEn),
    .feedbackDivide(feedbackDivide), .calPathSelect(calPathSelect), .loopFilterCfg(loopFilterCfg),
    .calBusy(calBusy));

  always #10 clock = ~clock;
  // random loop and sysref levels keep the bypass sources moving
  always @(negedge clock) {firstLoopIn, sysrefIn} <= 2'($random(seed));
  // read answers come one edge after the strobe
  always @(posedge clock) rdPend <= regRdEn;
  always @(negedge clock) if (rdPend === 1'b1) begin rdExp = expQ.pop_front(); `CHK(regRdData, rdExp) end
  // hang guard, far above the run length
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end

  task automatic chkRd(input logic [11:0] a, input logic [7:0] e);
    expQ.push_back(e);
    host.rd(a);
  endtask : chkRd
  task automatic waitBusy(input logic v, input int lim);
    for (int i = 0; i < lim && calBusy !== v; i++) @(negedge clock);
    `CHK(calBusy, v)
  endtask : waitBusy
  // rising-to-rising gives the ratio, rising-to-falling the duty
  task automatic period(input int f);
    time t0, t1, t2;
    @(posedge channelOut[0]);
    t0 = $time;
    @(negedge channelOut[0]);
    t1 = $time;
    @(posedge channelOut[0]);
    t2 = $time;
    `CHK(t2 - t0, time'((f + 1) * 20))
    `CHK(t1 - t0, time'((f + 1) * 10))
  endtask : period
  task automatic finish_test();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  initial begin
    resetn = 1'b0;
    firstLoopIn = 1'b0;
    sysrefIn = 1'b0;
    rdPend = 1'b0;
    repeat (2) @(posedge clock);
    @(negedge clock) resetn = 1'b1;
    chkRd(ADDR_FB_CFG_A, 8'h0A);
    chkRd(ADDR_FB_CFG_B, 8'h87);
    chkRd(ADDR_FB_CFG_C, 8'h01);
    chkRd(ADDR_FB_CFG_D, 8'h03);
    chkRd(ADDR_CAL_STATUS, 8'h00);
    chkRd(12'h7FF, 8'h00);
    `CHK(feedbackDivide, 11'h01E)
    `CHK(channelOut[13], 1'b0)
    // random loop setting, staged until the transfer
    n = 8'(6 + {$random(seed)} % 46);
    m = 3'(3 + {$random(seed)} % 3);
    fbExp = 11'(n) * 11'(m);
    host.setLoop(n, m);
    `CHK(feedbackDivide, 11'h01E)
    host.xfer();
    repeat (2) @(negedge clock);
    `CHK(feedbackDivide, fbExp)
    host.calStart();
    waitBusy(1'b1, 10);
    `CHK(calPathSelect, 1'b1)
    `CHK(feedbackDivide, fbExp)
    chkRd(ADDR_CAL_STATUS, 8'h01);
    waitBusy(1'b0, CAL + 10);
    `CHK(calPathSelect, 1'b0)
    `CHK(feedbackDivide, fbExp)
    chkRd(ADDR_CAL_STATUS, 8'h04);
    // bit left high: a further transfer must not restart
    host.xfer();
    repeat (5) @(negedge clock);
    `CHK(calBusy, 1'b0)
    host.wr(ADDR_CAL_STATUS, 8'hFF);
    chkRd(ADDR_CAL_STATUS, 8'h04);
    r = 5'(1 + {$random(seed)} % 31);
    lf = 8'($random(seed));
    host.wr(ADDR_FB_CFG_C, {3'h1, r});
    host.wr(ADDR_LOOP_FILTER, lf);
    host.wr(ADDR_CH_FINE + 12'h005, 8'h1A);
    host.wr(ADDR_CH_CTRL + 12'h006, 8'h02);
    host.wr(ADDR_CH_FINE + 12'h006, 8'h13);
    host.xfer();
    repeat (2) @(negedge clock);
    `CHK(refDivide, r)
    `CHK(refDoublerEn, 1'b1)
    `CHK(loopFilterCfg, lf)
    `CHK(fineDelayCfg[25 +: 5], 5'h1A)
    `CHK(fineDelayCfg[30 +: 5], 5'h13)
    host.wr(ADDR_FB_CFG_C, 8'h00);
    host.xfer();
    repeat (2) @(negedge clock);
    `CHK(refDivide, 5'h01)
    // each ratio: new field, sync set holds the channel, the clear restarts it
    foreach (divs[k]) begin
      host.wr(ADDR_CH_DIV, divs[k]);
      host.wr(ADDR_SYNC, 8'h01);
      host.xfer();
      repeat (4) @(negedge clock);
      for (int j = 0; j < 4; j++) @(negedge clock) `CHK(channelOut[0], 1'b0)
      host.wr(ADDR_SYNC, 8'h00);
      host.xfer();
      period(int'(divs[k]));
    end
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
